// [hdl/fcae_core.v]
// Purpose: aux encoder feedback path of a full-closed position loop, APB slave
// Assumes: encoder, command and discrete pins asynchronous to mclk
// Notes: one clock domain; each encoder, pulse-train and discrete pin passes two flip-flops first
// Operation
// - full-closed loop stays off while the aux index pair is not driven
// - only A/B quadrature is decoded from the aux input
// - sampling keeps up with 4MHz per phase
// - in pulse-train mode each command pulse gives num/den aux counts
// - internal-path full-closed needs mode 1, enable 1, loop-select input off
// - in internal-path mode each user unit gives num/den aux counts
// - internal-path mode clears loop error on full/half-closed switch
// - received aux position is readable and driven to the display port
// - enable field 0 disables, 1 enables the full-closed loop
// - direction field 0 counts up when A leads, 1 when B leads
// - source field routes motor, aux or command pulses to encoder outputs
// - filter field selects aux input filter, 0 bypasses it
// - counts per revolution kept within 200 to 1280000, default 5000
// - deviation alarm when aux and motor feedback drift too far apart
`include "fcae_regs.vh"

module fcae_core (
	input wire mclk, // 250 MHz clock
	input wire rst_b, // async reset, active low
	input wire psel, // apb select
	input wire penable, // apb access phase
	input wire pwrite, // apb write
	input wire [11:0] paddr, // apb byte address
	input wire [31:0] pwdata, // apb write data
	output reg [31:0] prdata, // apb read data
	output wire pready, // apb ready
	output wire pslverr, // apb error on unmapped address
	input wire aux_a, // aux phase a
	input wire aux_a_n, // aux phase a complement
	input wire aux_b, // aux phase b
	input wire aux_b_n, // aux phase b complement
	input wire aux_z, // aux index
	input wire aux_z_n, // aux index complement
	input wire mot_a, // motor encoder a
	input wire mot_b, // motor encoder b
	input wire mot_z, // motor encoder index
	input wire cmd_pulse, // pulse-train command pulse
	input wire cmd_sign, // pulse-train command direction
	input wire loop_half_sel, // discrete input: on selects half-closed in internal-path mode
	input wire path_step, // internal path unit step, mclk domain
	input wire path_dir, // internal path direction, 1 = negative
	output reg encoder_out_a, // encoder pulse output a
	output reg encoder_out_b, // encoder pulse output b
	output reg encoder_out_index, // encoder pulse output index
	output reg full_closed_active, // loop closed on aux feedback
	output reg [31:0] aux_position_monitor, // aux position for display
	output wire position_deviation_alarm, // deviation alarm level
	output wire irq // interrupt, high while unmasked status set
);

	// ****************************************
	// helpers
	// ****************************************
	// returns {move, up}; bit 1 is phase a, bit 0 phase b
	function [1:0] quad_step;
		input [1:0] prev;
		input [1:0] cur;
		begin
			quad_step = {^(prev ^ cur), prev[0] ^ cur[1]};
		end
	endfunction

	// ****************************************
	// registers
	// ****************************************
	reg [15:0] closed_loop_config;
	reg [31:0] aux_counts_per_rev;
	reg [3:0] control_mode_select;
	reg [15:0] gear_num;
	reg [15:0] gear_den;
	reg [31:0] dev_limit;
	reg [`FCAE_ST_W-1:0] status;
	reg [`FCAE_ST_W-1:0] mask;
	reg [11:0] sync1;
	reg [11:0] sync2;
	reg [1:0] filt;
	reg [3:0] fcnt [0:1];
	reg [1:0] aux_prev;
	reg [1:0] mot_prev;
	reg cmd_prev;
	reg [31:0] mot_pos;
	reg [31:0] target;
	reg signed [23:0] residue;
	reg signed [31:0] loop_err;
	reg signed [47:0] dev;
	reg dev_over_d;
	reg idx_lost_d;
	reg [31:0] next_rd;
	integer i;

	wire [3:0] loop_enable_field = closed_loop_config[`FCAE_CFG_EN_LSB+:4];
	wire [3:0] pulse_out_source_field = closed_loop_config[`FCAE_CFG_SRC_LSB+:4];
	wire [3:0] count_direction_field = closed_loop_config[`FCAE_CFG_DIR_LSB+:4];
	wire [3:0] input_filter_field = closed_loop_config[`FCAE_CFG_FILT_LSB+:4];

	// ****************************************
	// apb decode
	// ****************************************
	wire acc = psel & penable;
	wire wr = acc & pwrite;
	wire rd_status = acc & ~pwrite & (paddr == `FCAE_OFS_STATUS);
	reg mapped;
	always @*
	begin
		mapped = 1'b1;
		next_rd = 32'h0;
		if (paddr == `FCAE_OFS_CPR)
			next_rd = aux_counts_per_rev;
		else if (paddr == `FCAE_OFS_CFG)
			next_rd = {16'h0, closed_loop_config};
		else if (paddr == `FCAE_OFS_MODE)
			next_rd = {28'h0, control_mode_select};
		else if (paddr == `FCAE_OFS_GEAR_NUM)
			next_rd = {16'h0, gear_num};
		else if (paddr == `FCAE_OFS_GEAR_DEN)
			next_rd = {16'h0, gear_den};
		else if (paddr == `FCAE_OFS_AUX_POS)
			next_rd = aux_position_monitor;
		else if (paddr == `FCAE_OFS_LOOP_ERR)
			next_rd = loop_err;
		else if (paddr == `FCAE_OFS_DEV_LIMIT)
			next_rd = dev_limit;
		else if (paddr == `FCAE_OFS_STATUS)
			next_rd = {{(32-`FCAE_ST_W){1'b0}}, status};
		else if (paddr == `FCAE_OFS_MASK)
			next_rd = {{(32-`FCAE_ST_W){1'b0}}, mask};
		else if (paddr == `FCAE_OFS_TARGET)
			next_rd = target;
		else if (paddr == `FCAE_OFS_MOT_POS)
			next_rd = mot_pos;
		else
			mapped = 1'b0;
	end

	assign pready = 1'b1;
	assign pslverr = acc & ~mapped;

	// ****************************************
	// pin synchronisers
	// ****************************************
	wire [11:0] pins = {loop_half_sel, cmd_sign, cmd_pulse, mot_z, mot_b, mot_a,
		aux_z_n, aux_z, aux_b_n, aux_b, aux_a_n, aux_a};
	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sync1 <= 12'h000;
			sync2 <= 12'h000;
		end
		else
		begin
			sync1 <= pins;
			sync2 <= sync1;
		end
	end

	wire z_ok = sync2[4] ^ sync2[5];
	// only phases a and b decoded
	wire [1:0] aux_raw = {sync2[0], sync2[2]};
	wire [1:0] mot_ab = {sync2[6], sync2[7]};
	wire half_sel = sync2[11];

	// ****************************************
	// aux input filter
	// ****************************************
	// stable for filter-field cycles
	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			filt <= 2'h0;
			for (i = 0; i < 2; i = i + 1)
				fcnt[i] <= 4'h0;
		end
		else
		begin
			for (i = 0; i < 2; i = i + 1)
			begin
				if (input_filter_field == 4'h0 || aux_raw[i] == filt[i] ||
					fcnt[i] + 4'h1 >= input_filter_field)
				begin
					filt[i] <= aux_raw[i];
					fcnt[i] <= 4'h0;
				end
				else
					fcnt[i] <= fcnt[i] + 4'h1;
			end
		end
	end

	// ****************************************
	// quadrature decode and loop state
	// ****************************************
	// every rising mclk edge samples, far above edge rate
	// one count per a or b edge
	wire [1:0] aux_q = quad_step(aux_prev, filt);
	wire [1:0] mot_q = quad_step(mot_prev, mot_ab);
	wire aux_up = aux_q[0] ^ count_direction_field[0];

	wire loop_en = (loop_enable_field == `FCAE_FIELD_ON);
	wire mode_pt = (control_mode_select == `FCAE_MODE_PT);
	wire mode_pr = (control_mode_select == `FCAE_MODE_PR);
	wire pr_ok = mode_pr & loop_en & ~half_sel;
	wire next_active = z_ok & ((mode_pt & loop_en) | pr_ok);
	wire switched = next_active ^ full_closed_active;

	// command unit events
	wire pt_ev = mode_pt & sync2[9] & ~cmd_prev;
	wire pr_ev = mode_pr & path_step;
	wire ev_neg = pt_ev ? sync2[10] : path_dir;
	wire [15:0] den = (gear_den == 16'h0) ? 16'h1 : gear_den;
	wire signed [23:0] num_s = {8'h0, gear_num};
	wire signed [23:0] den_s = {8'h0, den};
	// pulse-train pulse adds num, each den gives one count
	// internal-path unit scaled the same way
	wire signed [23:0] res_add = (pt_ev | pr_ev) ? (ev_neg ? -num_s : num_s) : 24'sh0;
	wire signed [23:0] res_sum = residue + res_add;
	wire step_up = (res_sum >= den_s);
	wire step_dn = (res_sum <= -den_s);
	wire signed [31:0] tgt_d = step_up ? 32'sh1 : (step_dn ? -32'sh1 : 32'sh0);

	wire fb_mv = full_closed_active ? aux_q[1] : mot_q[1];
	wire fb_up = full_closed_active ? aux_up : mot_q[0];
	wire signed [31:0] fb_d = fb_mv ? (fb_up ? 32'sh1 : -32'sh1) : 32'sh0;

	// deviation accumulator: motor counts scaled by aux cpr vs aux counts
	wire signed [47:0] cpr_s = {16'h0, aux_counts_per_rev};
	wire signed [47:0] mcpr_s = `FCAE_MOTOR_CPR;
	wire signed [47:0] dev_m = mot_q[1] ? (mot_q[0] ? cpr_s : -cpr_s) : 48'sh0;
	wire signed [47:0] dev_a = aux_q[1] ? (aux_up ? mcpr_s : -mcpr_s) : 48'sh0;
	wire [47:0] dev_abs = dev[47] ? -dev : dev;
	wire [47:0] dev_thr = {16'h0, dev_limit} * `FCAE_MOTOR_CPR;
	wire dev_over = full_closed_active & (dev_abs > dev_thr);
	wire idx_lost = loop_en & ~z_ok;

	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			aux_prev <= 2'h0;
			mot_prev <= 2'h0;
			cmd_prev <= 1'b0;
			aux_position_monitor <= 32'h0;
			mot_pos <= 32'h0;
			target <= 32'h0;
			residue <= 24'sh0;
			loop_err <= 32'sh0;
			dev <= 48'sh0;
			full_closed_active <= 1'b0;
			dev_over_d <= 1'b0;
			idx_lost_d <= 1'b0;
		end
		else
		begin
			aux_prev <= filt;
			mot_prev <= mot_ab;
			cmd_prev <= sync2[9];
			full_closed_active <= next_active;
			dev_over_d <= dev_over;
			idx_lost_d <= idx_lost;
			if (aux_q[1])
				aux_position_monitor <= aux_up ? aux_position_monitor + 32'h1 :
					aux_position_monitor - 32'h1;
			if (mot_q[1])
				mot_pos <= mot_q[0] ? mot_pos + 32'h1 : mot_pos - 32'h1;
			residue <= res_sum - (step_up ? den_s : (step_dn ? -den_s : 24'sh0));
			target <= target + tgt_d;
			loop_err <= (switched & mode_pr) ? 32'sh0 : loop_err + tgt_d - fb_d;
			// drift between aux and motor feedback
			dev <= full_closed_active ? dev + dev_m - dev_a : 48'sh0;
		end
	end

	// ****************************************
	// encoder pulse outputs
	// ****************************************
	// output source select
	wire [2:0] next_enc = (pulse_out_source_field == `FCAE_SRC_MOTOR) ? {mot_ab, sync2[8]} :
		(pulse_out_source_field == `FCAE_SRC_AUX) ? {filt, sync2[4]} :
		(pulse_out_source_field == `FCAE_SRC_CMD) ? {sync2[9], sync2[10], 1'b0} : 3'h0;
	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			{encoder_out_a, encoder_out_b, encoder_out_index} <= 3'h0;
		else
			{encoder_out_a, encoder_out_b, encoder_out_index} <= next_enc;
	end

	// ****************************************
	// register file and interrupt status
	// ****************************************
	wire [`FCAE_ST_W-1:0] st_set = {switched, idx_lost & ~idx_lost_d, dev_over & ~dev_over_d};
	// clear only what the read returned
	wire [`FCAE_ST_W-1:0] st_clr = rd_status ? prdata[`FCAE_ST_W-1:0] : {`FCAE_ST_W{1'b0}};

	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			closed_loop_config <= `FCAE_RST_CFG;
			aux_counts_per_rev <= `FCAE_RST_CPR;
			control_mode_select <= `FCAE_RST_MODE;
			gear_num <= `FCAE_RST_GEAR;
			gear_den <= `FCAE_RST_GEAR;
			dev_limit <= `FCAE_RST_DEV_LIMIT;
			mask <= {`FCAE_ST_W{1'b0}};
			status <= {`FCAE_ST_W{1'b0}};
			prdata <= 32'h0;
		end
		else
		begin
			if (psel & ~penable & ~pwrite)
				prdata <= next_rd;
			// set wins over read clear
			status <= (status & ~st_clr) | st_set;
			if (wr)
			begin
				if (paddr == `FCAE_OFS_CFG)
					closed_loop_config <= pwdata[15:0];
				else if (paddr == `FCAE_OFS_CPR)
				begin
					if (pwdata >= `FCAE_CPR_MIN && pwdata <= `FCAE_CPR_MAX)
						aux_counts_per_rev <= pwdata;
				end
				else if (paddr == `FCAE_OFS_MODE)
					control_mode_select <= pwdata[3:0];
				else if (paddr == `FCAE_OFS_GEAR_NUM)
					gear_num <= pwdata[15:0];
				else if (paddr == `FCAE_OFS_GEAR_DEN)
					gear_den <= pwdata[15:0];
				else if (paddr == `FCAE_OFS_DEV_LIMIT)
					dev_limit <= pwdata;
				else if (paddr == `FCAE_OFS_MASK)
					mask <= pwdata[`FCAE_ST_W-1:0];
			end
		end
	end

	assign position_deviation_alarm = status[`FCAE_ST_DEV];
	assign irq = |(status & mask);

endmodule

// [hdl/fcae_regs.vh]
// Purpose: offsets, fields, reset values and counts of the aux encoder loop block
// Assumes: byte addresses on a 32-bit APB, one word per register
// Notes: included by fcae_core.v and by the checker and the bench
`ifndef FCAE_REGS_VH
`define FCAE_REGS_VH

// ****************************************
// register offsets
// ****************************************
`define FCAE_OFS_CPR 12'h190
`define FCAE_OFS_CFG 12'h194
`define FCAE_OFS_MODE 12'h198
`define FCAE_OFS_GEAR_NUM 12'h19c
`define FCAE_OFS_GEAR_DEN 12'h1a0
`define FCAE_OFS_AUX_POS 12'h1a4
`define FCAE_OFS_LOOP_ERR 12'h1a8
`define FCAE_OFS_DEV_LIMIT 12'h1ac
`define FCAE_OFS_STATUS 12'h1b0
`define FCAE_OFS_MASK 12'h1b4
`define FCAE_OFS_TARGET 12'h1b8
`define FCAE_OFS_MOT_POS 12'h1bc

// ****************************************
// config word fields
// ****************************************
`define FCAE_CFG_EN_LSB 0
`define FCAE_CFG_SRC_LSB 4
`define FCAE_CFG_DIR_LSB 8
`define FCAE_CFG_FILT_LSB 12
`define FCAE_FIELD_ON 4'h1
`define FCAE_SRC_MOTOR 4'h0
`define FCAE_SRC_AUX 4'h1
`define FCAE_SRC_CMD 4'h2

// ****************************************
// reset values and limits
// ****************************************
`define FCAE_RST_CFG 16'h0000
`define FCAE_RST_CPR 32'h00001388
`define FCAE_CPR_MIN 32'h000000c8
`define FCAE_CPR_MAX 32'h00138800
`define FCAE_RST_MODE 4'h0
`define FCAE_RST_GEAR 16'h0001
`define FCAE_RST_DEV_LIMIT 32'h00030000
`define FCAE_MOTOR_CPR 48'h000000002710
`define FCAE_MODE_PT 4'h0
`define FCAE_MODE_PR 4'h1

// ****************************************
// status bits
// ****************************************
`define FCAE_ST_DEV 0
`define FCAE_ST_IDX_LOST 1
`define FCAE_ST_SWITCH 2
`define FCAE_ST_W 3

// ****************************************
// timing: input rates the decoder must follow
// ****************************************
`define FCAE_MAX_PHASE_HZ 4000000
`define FCAE_CLK_HZ 250000000
`define FCAE_CYC_PER_PHASE (`FCAE_CLK_HZ / `FCAE_MAX_PHASE_HZ)

`endif

// [tb/fcae_enc_model.sv]
// Purpose: machine-end quadrature encoder on the aux pins
// Assumes: pins change just after a rising mclk edge
// Notes: a and b complements inverse; index complement tied low
module fcae_enc_model (
	input wire mclk, // clock
	output logic a = 1'b0, // phase a
	output wire a_n, // phase a complement
	output logic b = 1'b0, // phase b
	output wire b_n, // phase b complement
	output logic z = 1'b1, // index
	output wire z_n // index complement
);
timeunit 1ns;
timeprecision 1ps;
logic [1:0] st = 2'h0;
assign a_n = ~a;
assign b_n = ~b;
// index complement tied low; index driven low when no index
assign z_n = 1'b0;
task step(input bit up, input int gap);
	st = up ? st + 2'h1 : st - 2'h1;
	@(posedge mclk);
	a <= st[0] ^ st[1];
	b <= st[1];
	repeat (gap) @(posedge mclk);
endtask
task glitch(input int len);
	@(posedge mclk);
	a <= ~a;
	repeat (len) @(posedge mclk);
	a <= ~a;
endtask
task set_z(input bit present);
	z <= present;
endtask
endmodule

// [tb/fcae_core_chk.sv]
// Purpose: port assertions of fcae_core
// Assumes: register shadows follow apb writes
// Notes: bound from the bench top
`include "fcae_regs.vh"
module fcae_core_chk (
	input wire mclk, // clock
	input wire rst_b, // reset
	input wire psel, // select
	input wire penable, // access
	input wire pwrite, // write
	input wire [11:0] paddr, // address
	input wire [31:0] pwdata, // write data
	input wire [31:0] prdata, // read data
	input wire pslverr, // error
	input wire aux_a, // phase a
	input wire aux_b, // phase b
	input wire aux_z, // index
	input wire aux_z_n, // index complement
	input wire cmd_pulse, // command pulse
	input wire loop_half_sel, // half-closed select
	input wire encoder_out_a, // pulse out a
	input wire full_closed_active, // loop closed
	input wire [31:0] aux_position_monitor, // aux count
	input wire position_deviation_alarm, // alarm
	input wire irq // interrupt
);
timeunit 1ns;
timeprecision 1ps;
default clocking @(posedge mclk); endclocking
default disable iff (!rst_b);
wire acc = psel && penable;
wire hit = paddr >= 12'h190 && paddr <= 12'h1bc && paddr[1:0] == 2'h0;
reg [15:0] cfg;
reg [3:0] mode;
reg [2:0] msk;
always @(posedge mclk or negedge rst_b)
	if (!rst_b)
	begin
		cfg <= `FCAE_RST_CFG;
		mode <= `FCAE_RST_MODE;
		msk <= 3'h0;
	end
	else if (acc && pwrite)
	begin
		if (paddr == `FCAE_OFS_CFG)
			cfg <= pwdata[15:0];
		if (paddr == `FCAE_OFS_MODE)
			mode <= pwdata[3:0];
		if (paddr == `FCAE_OFS_MASK)
			msk <= pwdata[2:0];
	end
sequence s_idx_off;
	(aux_z == aux_z_n)[*5];
endsequence
sequence s_half;
	(mode == 4'h1 && loop_half_sel)[*5];
endsequence
chk_idx_gates_loop: assert property (s_idx_off |=> !full_closed_active)
	else $error("loop closed without index");
chk_en_gates_loop: assert property ((cfg[3:0] != 4'h1)[*3] |=> !full_closed_active)
	else $error("loop closed while disabled");
chk_loop_on: assert property ((cfg[3:0] == 4'h1 && mode == 4'h0 && aux_z && !aux_z_n)[*5]
	|=> full_closed_active) else $error("loop not closed");
chk_half_gates: assert property (s_half |=> !full_closed_active)
	else $error("loop closed in half mode");
chk_pos_unit: assert property ($changed(aux_position_monitor) |->
	(aux_position_monitor - $past(aux_position_monitor)) inside {32'h1, 32'hffffffff})
	else $error("aux count jumped");
chk_pos_hold: assert property ((cfg[15:12] == 4'h0 && $stable(aux_a) && $stable(aux_b))[*4]
	|=> $stable(aux_position_monitor)) else $error("aux count moved idle");
chk_src_cmd: assert property ((cfg[7:4] == 4'h2 && $stable(cmd_pulse))[*5]
	|-> encoder_out_a == cmd_pulse) else $error("pulse out not command");
chk_irq_alarm: assert property (position_deviation_alarm && msk[0] |-> irq)
	else $error("alarm irq missing");
chk_irq_masked: assert property (msk == 3'h0 |-> !irq)
	else $error("masked irq seen");
chk_unmapped_err: assert property (acc && !hit |-> pslverr && (pwrite || prdata == 32'h0))
	else $error("unmapped access not refused");
endmodule

// [tb/tb_fcae_core.sv]
// Purpose: self-checking bench of fcae_core
// Assumes: apb master tasks, encoder model on aux pins
// Notes: fixed seed, expectations computed here
`include "fcae_regs.vh"
module tb_fcae_core;
timeunit 1ns;
timeprecision 1ps;
logic mclk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
logic [11:0] paddr = 0;
logic [31:0] pwdata = 0, prdata, rv, pos;
logic mot_a = 0, mot_b = 0, cmd_pulse = 0, loop_half_sel = 0, path_step = 0;
logic mot_z = 0, cmd_sign = 0;
logic aux_a, aux_a_n, aux_b, aux_b_n, aux_z, aux_z_n, oa, ob, oz, act, alarm, irq;
int mismatches = 0, samples_checked = 0, k = 0, n, b0;
int lim[4] = '{199, 200, 1280001, 1280000};
int lx[4] = '{5000, 200, 200, 1280000};
always #2 mclk = ~mclk;
fcae_core i_fcae_core(.mclk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
	.pready, .pslverr, .aux_a, .aux_a_n, .aux_b, .aux_b_n, .aux_z, .aux_z_n, .mot_a, .mot_b,
	.mot_z, .cmd_pulse, .cmd_sign, .loop_half_sel, .path_step, .path_dir(1'b0),
	.encoder_out_a(oa), .encoder_out_b(ob), .encoder_out_index(oz), .full_closed_active(act),
	.aux_position_monitor(pos), .position_deviation_alarm(alarm), .irq);
fcae_enc_model i_fcae_enc_model(.mclk, .a(aux_a), .a_n(aux_a_n), .b(aux_b), .b_n(aux_b_n),
	.z(aux_z), .z_n(aux_z_n));
task results;
	$display("checked %0d mismatches %0d", samples_checked, mismatches);
	if (mismatches == 0 && samples_checked > 0)
		$display("NO MISMATCHES");
	else
		$display("MISMATCHES SEEN");
	$finish;
endtask
task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
	samples_checked++;
	if (seen !== exp)
	begin
		mismatches++;
		$display("ERROR %s expected %h seen %h", nm, exp, seen);
	end
endtask
task cyc(input int c);
	repeat (c) @(posedge mclk);
endtask
task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
	int t;
	t = 0;
	@(posedge mclk);
	psel <= 1'b1;
	pwrite <= w;
	paddr <= a;
	pwdata <= d;
	@(posedge mclk);
	penable <= 1'b1;
	do
	begin
		@(posedge mclk);
		t++;
	end
	while (pready !== 1'b1 && t < 20);
	rv = prdata;
	err = pslverr;
	psel <= 1'b0;
	penable <= 1'b0;
	if (t >= 20)
	begin
		mismatches++;
		results;
	end
endtask
function logic ea(input int e, input int md, input logic h, input int zok);
	return zok == 1 && e == 1 && (md == 0 || (md == 1 && !h));
endfunction
initial
begin
	void'($urandom(32'hdf6ffb3f));
	cyc(6);
	rst_b <= 1'b1;
	apb(0, `FCAE_OFS_CFG, 0);
	chk("cfg reset", rv, 32'h0);
	foreach (lim[i])
	begin
		apb(1, `FCAE_OFS_CPR, lim[i]);
		apb(0, `FCAE_OFS_CPR, 0);
		chk("cpr", rv, lx[i]);
	end
	apb(1, `FCAE_OFS_CPR, 5000);
	apb(0, 12'h1c0, 0);
	chk("unmapped", {err, rv[30:0]}, 32'h80000000);
	repeat (12)
	begin
		k = $urandom % 3;
		n = $urandom % 2;
		b0 = $urandom % 2;
		i_fcae_enc_model.set_z(b0[0]);
		loop_half_sel <= $urandom;
		apb(1, `FCAE_OFS_CFG, k);
		apb(1, `FCAE_OFS_MODE, n);
		cyc(6);
		chk("active", act, ea(k, n, loop_half_sel, b0));
	end
	i_fcae_enc_model.set_z(1'b1);
	loop_half_sel <= 1'b0;
	for (int d = 0; d < 2; d++)
	begin
		apb(1, `FCAE_OFS_CFG, d << 8);
		b0 = pos;
		n = 4 + $urandom % 9;
		repeat (n) i_fcae_enc_model.step(1, d ? 62 : 15);
		cyc(6);
		apb(0, `FCAE_OFS_AUX_POS, 0);
		chk("aux reg", rv, b0 + (d ? -n : n));
	end
	apb(1, `FCAE_OFS_CFG, 32'h3000);
	b0 = pos;
	i_fcae_enc_model.glitch(2);
	cyc(3);
	chk("glitch", pos, b0);
	i_fcae_enc_model.step(1, 15);
	chk("filtered step", pos, b0 + 1);
	repeat (2)
	begin
		mot_a <= $urandom;
		mot_b <= $urandom;
		mot_z <= $urandom;
		cmd_pulse <= $urandom;
		cmd_sign <= $urandom;
		i_fcae_enc_model.step($urandom % 2, 2);
		for (int s = 0; s < 4; s++)
		begin
			apb(1, `FCAE_OFS_CFG, s << 4);
			cyc(6);
			chk("out a", oa, s == 0 ? mot_a : s == 1 ? aux_a : s == 2 ? cmd_pulse : 1'b0);
			chk("out b", ob, s == 0 ? mot_b : s == 1 ? aux_b : s == 2 ? cmd_sign : 1'b0);
			chk("out z", oz, s == 0 ? mot_z : s == 1 ? aux_z : 1'b0);
		end
	end
	cmd_pulse <= 1'b0;
	cmd_sign <= 1'b0;
	apb(1, `FCAE_OFS_MODE, `FCAE_MODE_PT);
	apb(1, `FCAE_OFS_GEAR_NUM, 2);
	// direction 0 keeps aux and motor alike
	apb(1, `FCAE_OFS_CFG, 1);
	apb(0, `FCAE_OFS_TARGET, 0);
	b0 = rv;
	n = 1 + $urandom % 6;
	repeat (n)
	begin
		cmd_pulse <= 1'b1;
		cyc(4);
		cmd_pulse <= 1'b0;
		cyc(4);
	end
	cyc(6);
	apb(0, `FCAE_OFS_TARGET, 0);
	chk("pt target", rv - b0, 2 * n);
	apb(1, `FCAE_OFS_MODE, `FCAE_MODE_PR);
	mot_a <= 1'b0;
	mot_b <= 1'b0;
	loop_half_sel <= 1'b1;
	cyc(6);
	loop_half_sel <= 1'b0;
	cyc(6);
	apb(0, `FCAE_OFS_TARGET, 0);
	b0 = rv;
	repeat (n)
	begin
		path_step <= 1'b1;
		@(posedge mclk);
		path_step <= 1'b0;
		cyc(2);
	end
	cyc(4);
	apb(0, `FCAE_OFS_TARGET, 0);
	chk("pr target", rv - b0, 2 * n);
	apb(0, `FCAE_OFS_LOOP_ERR, 0);
	chk("loop err", rv, 2 * n);
	loop_half_sel <= 1'b1;
	cyc(6);
	apb(0, `FCAE_OFS_LOOP_ERR, 0);
	chk("err cleared", rv, 0);
	apb(1, `FCAE_OFS_MODE, `FCAE_MODE_PT);
	apb(1, `FCAE_OFS_DEV_LIMIT, 1);
	k = 0;
	apb(0, `FCAE_OFS_STATUS, 0);
	repeat (3)
	begin
		k++;
		mot_a <= k[0] ^ k[1];
		mot_b <= k[1];
		cyc(6);
	end
	chk("alarm no irq", {alarm, irq}, 2'b10);
	apb(1, `FCAE_OFS_MASK, 1);
	cyc(1);
	chk("irq", irq, 1);
	apb(0, `FCAE_OFS_STATUS, 0);
	chk("status dev", rv[0], 1);
	cyc(1);
	chk("irq cleared", irq, 0);
	results;
end
endmodule
bind fcae_core fcae_core_chk i_fcae_core_chk(.mclk, .rst_b, .psel, .penable, .pwrite, .paddr,
	.pwdata, .prdata, .pslverr, .aux_a, .aux_b, .aux_z, .aux_z_n, .cmd_pulse, .loop_half_sel,
	.encoder_out_a, .full_closed_active, .aux_position_monitor, .position_deviation_alarm, .irq);
